// file: pkg/gpq_regs.svh
// gpq constants: widths, reset values, field positions of the pin block
// assumes inclusion by the package and the design files, by bare name
`ifndef GPQ_REGS_SVH
`define GPQ_REGS_SVH

`define GPQ_NUM_PINS    88
`define GPQ_QUAL_PINS   64
`define GPQ_PORT_W      32
`define GPQ_NUM_PORTS   3
`define GPQ_GRP_SIZE    8
`define GPQ_PER_W       8
`define GPQ_SYNC_DEPTH  3
`define GPQ_WIN_LONG    3'h6
`define GPQ_WIN_SHORT   3'h3
`define GPQ_CNT_MAX     3'h6
`define GPQ_PORTC_MASK  32'h00FFFFFF
`define GPQ_LATCH_RST   32'h00000000
`define GPQ_GATE_AB_RST 32'h00000000
`define GPQ_GC_TMR_LSB  8
`define GPQ_GC_XMEM     12
`define GPQ_GC_GPIN     13
`define GPQ_GATE_C_RST  32'h00002700

`endif

// file: pkg/gpq_pkg.sv
// gpq types shared by the pin block modules
// assumes gpq_regs.svh on the include path
`include "gpq_regs.svh"

package gpq_pkg;

  // input qualification choice per pin; the zero code is plain synchronisation
  typedef enum logic [1:0] {
    QM_SYNC,
    QM_WIN,
    QM_ASYNC
  } gpq_qmode_t;

  // which register a write strobe lands in
  typedef enum logic [2:0] {
    TG_DAT,
    TG_SET,
    TG_CLR,
    TG_GATE_A,
    TG_GATE_B,
    TG_GATE_R,
    TG_GATE_C
  } gpq_tgt_t;

  // one processor write: target, port, 16-bit lanes and data
  typedef struct packed {
    logic        en;
    gpq_tgt_t    tgt;
    logic [1:0]  port;
    logic [1:0]  lanes;
    logic [31:0] data;
  } gpq_wr_t;

endpackage : gpq_pkg

// file: verilog/gpq_qual.sv
// gpq_qual: synchroniser plus sample-window qualifier for one pin
// assumes i_smp is a one-cycle enable from the group's period divider
`timescale 1ns/1ps
`default_nettype none
`include "gpq_regs.svh"

module gpq_qual
  import gpq_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_run,
  input  wire logic       i_smp,
  input  wire logic       i_win6,
  input  wire gpq_qmode_t i_mode,
  input  wire logic       i_raw,
  output logic            o_sync,
  output logic            o_qual
);

  logic       meta_ff, sync_ff, last_ff, qual_ff;
  logic       nxt_meta, nxt_sync, nxt_last, nxt_qual;
  logic [2:0] cnt_ff, nxt_cnt, need;
  logic       win_hit;

  always_comb
  begin
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    nxt_last = last_ff;
    nxt_cnt  = cnt_ff;
    nxt_qual = qual_ff;
    need     = i_win6 ? `GPQ_WIN_LONG : `GPQ_WIN_SHORT;
    win_hit  = 1'b0;
    // a stopped input clock freezes all sampling
    if (i_run)
    begin
      // two flops before anyone looks at the pin
      nxt_meta = i_raw;
      nxt_sync = meta_ff;
      if (i_smp)
      begin
        nxt_last = sync_ff;
        if (sync_ff != last_ff)
          nxt_cnt = 3'h1;
        else if (cnt_ff != `GPQ_CNT_MAX)
          nxt_cnt = cnt_ff + 3'h1;
      end
      // accept only after enough equal samples
      win_hit = i_smp && (nxt_cnt >= need);
      // code zero, the reset default, is sync-only
      if (i_mode == QM_SYNC)
        nxt_qual = sync_ff;
      else if (i_mode == QM_WIN && win_hit)
        nxt_qual = sync_ff;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
      cnt_ff  <= 3'h0;
      qual_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
      cnt_ff  <= nxt_cnt;
      qual_ff <= nxt_qual;
    end
  end

  assign o_sync = sync_ff;
  // raw path is only meant for peripheral inputs
  assign o_qual = (i_mode == QM_ASYNC) ? i_raw : qual_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_sync_run;
    (i_run && i_mode == QM_SYNC) [*3];
  endsequence

  chk_win_accept: assert property (
    (i_mode == QM_WIN && $past(i_mode) == QM_WIN && qual_ff != $past(qual_ff))
      |-> $past(win_hit))
    else $error("window output moved without a full window");

  chk_sync_latency: assert property (
    s_sync_run ##1 1'b1 |-> qual_ff == $past(i_raw, 3))
    else $error("sync-only path latency wrong");

  chk_win_stop: assert property (
    !i_run |=> $stable(qual_ff) && $stable(sync_ff))
    else $error("sampling ran with input clock off");

endmodule : gpq_qual

`default_nettype wire

// file: verilog/gpq_top.sv
// gpq_top: 88-pin port block with muxing, qualification, wake select, clock gates
// assumes pads outside resolve out/oe/pull-up; config words come from software ports
`timescale 1ns/1ps
`default_nettype none
`include "gpq_regs.svh"

// Functional notes
// - pins 0-31 form port A, 32-63 port B, 64-87 port C.
// - data, set and clear writes accept 16-bit or 32-bit lanes.
// - each pin picks software I/O or one of three peripheral signals.
// - each port has two mux words holding all its pin selects.
// - pins 0-63 get selectable qualification; pins 64-87 only synchronise.
// - after reset qualifiable pins default to sync-only mode.
// - window mode accepts a change after enough equal consecutive samples.
// - window length is six or three samples, chosen per pin.
// - one sampling period setting is shared by each eight-pin group.
// - each pin has a software-controlled pull-up.
// - data reads return the sensed pin level, not the latch.
// - readback lags a data write by the input path delay.
// - set and clear writes change selected latch bits in one cycle.
// - any of pins 0-31 may be chosen as a low-power wake source.
// - several wake sources may be enabled together.
// - gate C covers timers, memory interface, pin inputs; resets timers/inputs on.
// - stopping the pin input clock halts all input sampling.
// - gates live in registers a, b and c; the reserved one does nothing.
module gpq_top
  import gpq_pkg::*;
#(
  parameter int NUM_PINS  = `GPQ_NUM_PINS,
  parameter int QUAL_PINS = `GPQ_QUAL_PINS
)
(
  input  wire logic                       i_clk,
  input  wire logic                       i_sys_rst,
  input  wire logic [NUM_PINS-1:0]        i_pin_in,
  output logic      [NUM_PINS-1:0]        o_pin_out,
  output logic      [NUM_PINS-1:0]        o_pin_oe,
  output logic      [NUM_PINS-1:0]        o_pin_pu,
  input  wire logic [NUM_PINS-1:0]        i_pullup_en,
  input  wire logic [NUM_PINS-1:0]        i_dir,
  input  wire logic [2*96-1:0]            i_mux_sel,
  input  wire logic [3*NUM_PINS-1:0]      i_per_out,
  input  wire logic [3*NUM_PINS-1:0]      i_per_oe,
  output logic      [NUM_PINS-1:0]        o_per_in,
  input  wire logic [2*QUAL_PINS-1:0]     i_qual_mode,
  input  wire logic [QUAL_PINS-1:0]       i_win6,
  input  wire logic [QUAL_PINS-1:0]       i_qual_period,
  input  wire gpq_wr_t                    i_wr,
  output logic      [3*`GPQ_PORT_W-1:0]   o_pin_data,
  input  wire logic [31:0]                i_wake_sel,
  output logic                            o_wake,
  output logic      [31:0]                o_gate_a,
  output logic      [31:0]                o_gate_b,
  output logic      [2:0]                 o_timer_clk_en,
  output logic                            o_xmem_clk_en,
  output logic                            o_gpio_in_clk_en
);

  localparam int NGRP = QUAL_PINS / `GPQ_GRP_SIZE;

  // three 32-bit ports, port C tops out at pin 87
  logic [3*`GPQ_PORT_W-1:0] lat_ff, nxt_lat;
  logic [3*`GPQ_PORT_W-1:0] data_ff, nxt_data;
  logic [31:0]              gate_a_ff, gate_b_ff, gate_c_ff;
  logic [31:0]              nxt_gate_a, nxt_gate_b, nxt_gate_c;
  logic [NUM_PINS-1:0]      pout_ff, poe_ff, ppu_ff;
  logic [NUM_PINS-1:0]      nxt_pout, nxt_poe;
  logic                     wake_ff, nxt_wake;
  logic [NUM_PINS-1:0]      sync_v, qual_v;
  logic [NGRP-1:0]          grp_smp;
  logic                     run;
  logic [31:0]              wmask, wbits, word, cur_word;
  logic [6:0]               base;

  assign run = gate_c_ff[`GPQ_GC_GPIN];

  // one period divider per eight-pin group
  generate
    for (genvar g = 0; g < NGRP; g++)
    begin : g_grp
      logic [`GPQ_PER_W-1:0] div_ff, nxt_div;
      always_comb
      begin
        nxt_div = div_ff;
        if (run)
          nxt_div = (div_ff == '0) ? i_qual_period[g*`GPQ_PER_W +: `GPQ_PER_W]
                                   : div_ff - 1'b1;
      end
      always_ff @(posedge i_clk)
      begin
        if (i_sys_rst)
          div_ff <= '0;
        else
          div_ff <= nxt_div;
      end
      assign grp_smp[g] = run && (div_ff == '0);
    end
  endgenerate

  generate
    for (genvar i = 0; i < NUM_PINS; i++)
    begin : g_pin
      logic [1:0] sel;
      logic [2:0] po, pe;
      gpq_qmode_t mode;
      logic       w6, smp;
      // upper port has no qualifier, plain sync only
      if (i < QUAL_PINS)
      begin : g_q
        assign mode = gpq_qmode_t'(i_qual_mode[2*i +: 2]);
        assign w6   = i_win6[i];
        assign smp  = grp_smp[i / `GPQ_GRP_SIZE];
      end
      else
      begin : g_nq
        assign mode = QM_SYNC;
        assign w6   = 1'b0;
        assign smp  = 1'b0;
      end
      gpq_qual u_qual (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_run     (run),
        .i_smp     (smp),
        .i_win6    (w6),
        .i_mode    (mode),
        .i_raw     (i_pin_in[i]),
        .o_sync    (sync_v[i]),
        .o_qual    (qual_v[i])
      );
      // two mux words per port, two bits per pin
      assign sel = i_mux_sel[2*i +: 2];
      assign po  = i_per_out[3*i +: 3];
      assign pe  = i_per_oe[3*i +: 3];
      // select 0 is software I/O, 1..3 the peripherals
      assign nxt_pout[i] = (sel == 2'h0) ? lat_ff[i] : po[sel - 2'h1];
      assign nxt_poe[i]  = (sel == 2'h0) ? i_dir[i]  : pe[sel - 2'h1];
    end
  endgenerate

  // each 16-bit lane enables its half of the word
  assign wmask = {{16{i_wr.lanes[1]}}, {16{i_wr.lanes[0]}}};
  assign wbits = wmask & i_wr.data;
  assign base  = {i_wr.port, 5'h00};

  always_comb
  begin
    nxt_lat    = lat_ff;
    nxt_gate_a = gate_a_ff;
    nxt_gate_b = gate_b_ff;
    nxt_gate_c = gate_c_ff;
    cur_word   = lat_ff[base +: 32];
    word       = cur_word;
    if (i_wr.en && i_wr.port != 2'h3)
    begin
      case (i_wr.tgt)
        TG_DAT:    word = (cur_word & ~wmask) | wbits;
        // set and clear act in the write cycle, no read needed
        TG_SET:    word = cur_word | wbits;
        TG_CLR:    word = cur_word & ~wbits;
        TG_GATE_A: nxt_gate_a = (gate_a_ff & ~wmask) | wbits;
        TG_GATE_B: nxt_gate_b = (gate_b_ff & ~wmask) | wbits;
        // timers, memory interface, pin input clock
        TG_GATE_C: nxt_gate_c = (gate_c_ff & ~wmask) | wbits;
        TG_GATE_R: word = cur_word;
        default:   word = cur_word;
      endcase
      nxt_lat[base +: 32] = word;
    end
    nxt_lat[64 +: 32] = nxt_lat[64 +: 32] & `GPQ_PORTC_MASK;
  end

  // readback is the synchronised pin, never the latch
  always_comb
  begin
    nxt_data = '0;
    nxt_data[NUM_PINS-1:0] = sync_v;
  end

  // any pin 0-31; several may be enabled at once
  assign nxt_wake = |(qual_v[31:0] & i_wake_sel);

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      lat_ff    <= {3{`GPQ_LATCH_RST}};
      data_ff   <= '0;
      gate_a_ff <= `GPQ_GATE_AB_RST;
      gate_b_ff <= `GPQ_GATE_AB_RST;
      // timers and input logic on, memory interface off
      gate_c_ff <= `GPQ_GATE_C_RST;
      pout_ff   <= '0;
      poe_ff    <= '0;
      ppu_ff    <= '0;
      wake_ff   <= 1'b0;
    end
    else
    begin
      lat_ff    <= nxt_lat;
      data_ff   <= nxt_data;
      gate_a_ff <= nxt_gate_a;
      gate_b_ff <= nxt_gate_b;
      gate_c_ff <= nxt_gate_c;
      pout_ff   <= nxt_pout;
      poe_ff    <= nxt_poe;
      ppu_ff    <= i_pullup_en;
      wake_ff   <= nxt_wake;
    end
  end

  assign o_pin_out        = pout_ff;
  assign o_pin_oe         = poe_ff;
  assign o_pin_pu         = ppu_ff;
  // async-mode pins reach peripherals without any flop
  assign o_per_in         = qual_v;
  // three cycles from pin to readback, so quick rmw may see old level
  assign o_pin_data       = data_ff;
  assign o_wake           = wake_ff;
  assign o_gate_a         = gate_a_ff;
  assign o_gate_b         = gate_b_ff;
  assign o_timer_clk_en   = gate_c_ff[`GPQ_GC_TMR_LSB +: 3];
  // writes to the memory interface need this high first
  assign o_xmem_clk_en    = gate_c_ff[`GPQ_GC_XMEM];
  assign o_gpio_in_clk_en = run;

  // checks on the port behaviour
  logic [15:0] lat_a_hi;
  logic        dir0;
  logic        per0_out, per0_oe;
  assign lat_a_hi = lat_ff[31:16];
  assign dir0     = i_dir[0];
  // peripheral bit that pin 0 picks when its select is non-zero
  assign per0_out = i_per_out[i_mux_sel[1:0] - 2'h1];
  assign per0_oe  = i_per_oe[i_mux_sel[1:0] - 2'h1];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_wr(gpq_tgt_t t);
    i_wr.en && i_wr.tgt == t && i_wr.port == 2'h0;
  endsequence

  sequence s_in_run;
    (run && !i_sys_rst) [*2] ##2 1'b1;
  endsequence

  // three running cycles let a pin reach the qualifier flop
  sequence s_run3;
    run [*3] ##1 1'b1;
  endsequence

  chk_set_bits: assert property (
    s_wr(TG_SET) |=> (lat_ff[31:0] & $past(wbits)) == $past(wbits))
    else $error("set write did not raise bits");

  chk_clr_bits: assert property (
    s_wr(TG_CLR) |=> (lat_ff[31:0] & $past(wbits)) == 32'h00000000)
    else $error("clear write did not drop bits");

  chk_lane_keep: assert property (
    (s_wr(TG_DAT) and (i_wr.lanes == 2'h1)) |=> lat_a_hi == $past(lat_a_hi))
    else $error("16-bit write touched upper half");

  chk_gate_reset: assert property (
    $past(i_sys_rst) |-> (o_timer_clk_en == 3'h7 && !o_xmem_clk_en && run))
    else $error("gate c reset value wrong");

  chk_rsv_ignore: assert property (
    (i_wr.en && i_wr.tgt == TG_GATE_R) |=> $stable(lat_ff) && $stable(gate_c_ff))
    else $error("reserved gate write had an effect");

  chk_wake_any: assert property (
    (|(qual_v[31:0] & i_wake_sel)) |=> o_wake)
    else $error("selected wake pin did not wake");

  chk_pin_readback: assert property (
    s_in_run |-> o_pin_data[NUM_PINS-1:0] == $past(i_pin_in, 3))
    else $error("readback not the pin level");

  chk_gpio_mux: assert property (
    (i_mux_sel[1:0] == 2'h0) |=> o_pin_oe[0] == $past(dir0))
    else $error("software direction not on pin 0");

  chk_per_mux: assert property (
    (i_mux_sel[1:0] != 2'h0)
      |=> o_pin_out[0] == $past(per0_out) && o_pin_oe[0] == $past(per0_oe))
    else $error("peripheral signal not on pin 0");

  chk_latch_drive: assert property (
    (i_mux_sel[1:0] == 2'h0) |=> o_pin_out[0] == $past(lat_ff[0]))
    else $error("latch bit not driven on pin 0");

  chk_dat_word: assert property (
    (s_wr(TG_DAT) and (i_wr.lanes == 2'h3)) |=> lat_ff[31:0] == $past(i_wr.data))
    else $error("32-bit data write not taken");

  // a write aimed at the missing fourth port must leave every register alone
  chk_port_ignore: assert property (
    (i_wr.en && i_wr.port == 2'h3) |=> $stable({lat_ff, gate_a_ff, gate_b_ff, gate_c_ff}))
    else $error("write to port 3 changed state");

  chk_gate_a_word: assert property (
    (i_wr.en && i_wr.tgt == TG_GATE_A && i_wr.port != 2'h3 && i_wr.lanes == 2'h3)
      |=> o_gate_a == $past(i_wr.data))
    else $error("gate a write not taken");

  chk_gate_c_word: assert property (
    (i_wr.en && i_wr.tgt == TG_GATE_C && i_wr.port != 2'h3 && i_wr.lanes == 2'h3)
      |=> gate_c_ff == $past(i_wr.data))
    else $error("gate c write not taken");

  // port c has 24 pins; its top latch and readback bits must stay clear
  chk_portc_mask: assert property (
    lat_ff[3*`GPQ_PORT_W-1:NUM_PINS] == '0)
    else $error("port c latch holds bits above pin 87");

  chk_read_pad: assert property (
    o_pin_data[3*`GPQ_PORT_W-1:NUM_PINS] == '0)
    else $error("readback shows bits above pin 87");

  // the last pin has no qualifier, so three cycles after the pad it must follow
  chk_upper_sync: assert property (
    s_run3 |-> o_per_in[NUM_PINS-1] == $past(i_pin_in[NUM_PINS-1], 3))
    else $error("upper pin not plain synchronised");

  chk_wake_idle: assert property (
    !(|(qual_v[31:0] & i_wake_sel)) |=> !o_wake)
    else $error("wake raised with no selected pin high");

  chk_pullup_copy: assert property (
    1'b1 |=> o_pin_pu == $past(i_pullup_en))
    else $error("pull-up enable not passed to the pin");

  // dividers must hold too, or sampling phase drifts while the clock is off
  chk_smp_stop: assert property (
    !run |=> $stable(g_grp[0].div_ff))
    else $error("period divider ran with input clock off");

endmodule : gpq_top

`default_nettype wire

// file: verif/gpq_pad_model.sv
// gpq_pad_model: pad ring plus far-side drivers of the pin block
// assumes the bench supplies external levels and their enables
`timescale 1ns/1ps
`default_nettype none
module gpq_pad_model
(
  input  wire logic        i_clk,
  input  wire logic [87:0] i_out,
  input  wire logic [87:0] i_oe,
  input  wire logic [87:0] i_pu,
  input  wire logic [87:0] i_ext,
  input  wire logic [87:0] i_ext_en,
  output logic      [87:0] o_pin
);
  logic [87:0] float_ff = '0;

  // undriven, unpulled pads wander so no stale level survives
  always @(posedge i_clk)
    float_ff <= ~float_ff;

  // pull-up level, driven level seen on the pad
  always_comb
    o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
          | (~i_oe & ~i_ext_en & (i_pu | float_ff));
endmodule : gpq_pad_model
`default_nettype wire

// file: verif/tb_gpq_top.sv
// tb_gpq_top: self-checking bench of the pin block against a bench model
// assumes gpq_pkg and the pad model are compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "gpq_regs.svh"
module tb_gpq_top
  import gpq_pkg::*;
  ;
  logic          clk;
  logic          rst;
  logic [87:0]   pin, pin_out, pin_oe, pin_pu, pu_en, dir, ext, ext_en, per_in, e;
  logic [191:0]  mux;
  logic [263:0]  per_out, per_oe;
  logic [127:0]  qmode;
  logic [63:0]   win6, period;
  gpq_wr_t       wr;
  logic [95:0]   pin_data, prev;
  logic [31:0]   wake_sel, gate_a, gate_b, ga, gb, gc, sel;
  logic [31:0]   lat [3];
  logic [2:0]    tmr_en;
  logic          wake, xmem_en, gin_en, seen;
  int            bad_count, compares;

  gpq_top i_gpq_top (.i_clk(clk), .i_sys_rst(rst), .i_pin_in(pin), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_pin_pu(pin_pu), .i_pullup_en(pu_en), .i_dir(dir), .i_mux_sel(mux),
    .i_per_out(per_out), .i_per_oe(per_oe), .o_per_in(per_in), .i_qual_mode(qmode),
    .i_win6(win6), .i_qual_period(period), .i_wr(wr), .o_pin_data(pin_data),
    .i_wake_sel(wake_sel), .o_wake(wake), .o_gate_a(gate_a), .o_gate_b(gate_b),
    .o_timer_clk_en(tmr_en), .o_xmem_clk_en(xmem_en), .o_gpio_in_clk_en(gin_en));

  gpq_pad_model i_gpq_pad_model (.i_clk(clk), .i_out(pin_out), .i_oe(pin_oe), .i_pu(pin_pu),
    .i_ext(ext), .i_ext_en(ext_en), .o_pin(pin));

  task automatic check(input string what, input logic [95:0] seen_v, input logic [95:0] exp);
    compares++;
    if (seen_v !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen_v);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  function automatic logic [87:0] exp_pins();
    return {lat[2][23:0], lat[1], lat[0]};
  endfunction : exp_pins

  task automatic write(input gpq_tgt_t t, input logic [1:0] p, input logic [1:0] ln,
                       input logic [31:0] d);
    logic [31:0] m;
    m = {{16{ln[1]}}, {16{ln[0]}}} & d;
    @(posedge clk);
    wr <= '{1'b1, t, p, ln, d};
    @(posedge clk);
    wr.en <= 1'b0;
    if (p != 2'h3)
      case (t)
        TG_DAT:    lat[p] = (lat[p] & ~{{16{ln[1]}}, {16{ln[0]}}}) | m;
        TG_SET:    lat[p] = lat[p] | m;
        TG_CLR:    lat[p] = lat[p] & ~m;
        TG_GATE_A: ga = (ga & ~{{16{ln[1]}}, {16{ln[0]}}}) | m;
        TG_GATE_B: gb = (gb & ~{{16{ln[1]}}, {16{ln[0]}}}) | m;
        TG_GATE_C: gc = (gc & ~{{16{ln[1]}}, {16{ln[0]}}}) | m;
        default:   ;
      endcase
    lat[2] = lat[2] & `GPQ_PORTC_MASK;
  endtask : write

  task automatic conclude();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial
  begin
    rst = 1'b1; wr = '0; pu_en = '0; dir = '1; ext = '0; ext_en = '0; mux = '0;
    per_out = '0; per_oe = '0; qmode = '0; win6 = '0; period = '0; wake_sel = '0;
    lat[0] = '0; lat[1] = '0; lat[2] = '0; ga = '0; gb = '0; gc = `GPQ_GATE_C_RST;
    void'($urandom(32'h184C));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    check("gate c", 96'({tmr_en, xmem_en, gin_en}), 96'(5'h1D));
    check("gate ab", 96'({gate_a, gate_b}), 96'h0);
    $display("test reset done");
    for (int i = 0; i < 24; i++)
    begin
      prev = 96'(exp_pins());
      write(gpq_tgt_t'(3'($urandom_range(2))), 2'($urandom_range(3)),
            2'($urandom_range(3)), $urandom);
      tick(2);
      check("pin out", 96'(pin_out), 96'(exp_pins()));
      check("stale data", pin_data, prev);
      tick(3);
      check("pin data", pin_data, 96'(exp_pins()));
    end
    check("pin oe", 96'(pin_oe), 96'({88{1'b1}}));
    $display("test latch done");
    @(posedge clk);
    dir <= '0;
    pu_en <= 88'({$urandom, $urandom, $urandom});
    tick(1);
    check("pull up", 96'(pin_pu), 96'(pu_en));
    @(posedge clk);
    pu_en <= '1;
    tick(6);
    check("pulled data", pin_data, 96'({88{1'b1}}));
    $display("test pullup done");
    for (int i = 0; i < 8; i++)
    begin
      sel = $urandom | 32'h1;
      @(posedge clk);
      wake_sel <= sel;
      ext_en <= '1;
      ext <= 88'(~sel | ((i % 2 == 1) ? (sel & (~sel + 32'h1)) : 32'h0));
      tick(6);
      check("wake", 96'(wake), 96'(i % 2));
    end
    $display("test wake done");
    for (int k = 1; k < 4; k++)
    begin
      @(posedge clk);
      mux <= {96{2'(k)}};
      per_out <= 264'({9{$urandom}});
      per_oe <= '1;
      // unsynchronised mode only on a peripheral input
      qmode[1:0] <= 2'h2;
      tick(1);
      for (int i = 0; i < 88; i++)
        e[i] = per_out[3 * i + k - 1];
      check("mux out", 96'(pin_out), 96'(e));
      check("async in", 96'(per_in[0]), 96'(e[0]));
    end
    @(posedge clk);
    mux <= '0;
    per_oe <= '0;
    qmode <= {116'h0, 2'h1, 10'h0};
    ext <= '0;
    $display("test mux done");
    for (int w = 0; w < 2; w++)
    begin
      @(posedge clk);
      win6[5] <= w[0];
      tick(10);
      @(posedge clk);
      ext[6:5] <= 2'h3;
      seen = 1'b0;
      for (int c = 1; c <= 14; c++)
      begin
        @(posedge clk);
        if (c == 4)
          ext[6:5] <= 2'h0;
        #1;
        if (c == 2)
          check("sync early", 96'(per_in[6]), 96'h0);
        if (c == 3)
          check("sync", 96'(per_in[6]), 96'h1);
        seen = seen | per_in[5];
      end
      check("window", 96'(seen), 96'(w == 0));
    end
    $display("test window done");
    write(TG_GATE_A, 2'h0, 2'h3, $urandom);
    write(TG_GATE_B, 2'h0, 2'h3, $urandom);
    write(TG_GATE_R, 2'h0, 2'h3, $urandom);
    // memory interface clock on, timer and pin input clocks off
    write(TG_GATE_C, 2'h0, 2'h1, 32'h00001000);
    tick(1);
    check("gates", 96'({gate_a, gate_b}), 96'({ga, gb}));
    check("gate c", 96'({tmr_en, xmem_en, gin_en}), 96'({gc[10:8], gc[12], gc[13]}));
    prev = pin_data;
    @(posedge clk);
    ext <= 88'({$urandom, $urandom, $urandom});
    tick(8);
    check("frozen", pin_data, prev);
    write(TG_GATE_C, 2'h0, 2'h3, 32'h00003700);
    tick(6);
    check("thawed", pin_data, 96'(ext));
    $display("test gates done");
    conclude();
  end
endmodule : tb_gpq_top
`default_nettype wire
